// ### design/dmad_cfg.svh
// Field positions, codes and constants of the DMA instruction dispatcher.
`ifndef DMAD_CFG_SVH
`define DMAD_CFG_SVH

`define DMAD_OPC_HI      31
`define DMAD_OPC_LO      29
`define DMAD_OPC_DMA     3'h3
`define DMAD_SEL_HI      28
`define DMAD_SEL_LO      27
`define DMAD_SEL_P1_RD   2'h0
`define DMAD_SEL_P1_WR   2'h1
`define DMAD_SEL_P2_RD   2'h2
`define DMAD_SEL_P2_WR   2'h3
`define DMAD_INC_BIT     26
`define DMAD_BC_HI       26
`define DMAD_BCP_HI      25
`define DMAD_BC_LO       19
`define DMAD_RLA_HI      18
`define DMAD_RLA_LO      14
`define DMAD_RSA_HI      13
`define DMAD_RSA_LO      10
`define DMAD_CTL_HI      9
`define DMAD_CTL_LO      5
`define DMAD_RSB_HI      4
`define DMAD_RSB_LO      0
`define DMAD_RLA_STEP    9'h040
`define DMAD_BUF_W       9
`define DMAD_BUF_N       32
`define DMAD_IDX_W       5
`define DMAD_LEN_W       8
`define DMAD_OPND_W      16
`define DMAD_BUF_RST     9'h000
`define DMAD_LEN_RST     8'h00
`define DMAD_ADDR_RST    32'h0000_0000

`endif

// ### design/dmad_pkg.sv
// Types shared by the DMA instruction dispatcher and its checks, queue model and bench.
`include "dmad_cfg.svh"

package dmad_pkg;

  typedef enum logic [1:0] {
    DMAD_IDLE,
    DMAD_FETCH,
    DMAD_ISSUE
  } dmad_state_t;

  // Control field as laid out in instruction bits 9 down to 5.
  typedef struct packed {
    logic inline_count_flag;
    logic crc_accum_x_enable;
    logic crc_accum_y_enable;
    logic completion_count_update;
    logic silent_transfer;
  } dmad_ctrl_t;

  // Value of the alternate count register as seen by the dispatcher.
  typedef struct packed {
    logic                    crc_accum_y_enable;
    logic                    crc_accum_x_enable;
    logic [`DMAD_LEN_W-1:0]  length_field;
  } dmad_alt_t;

  // One transfer request handed to a port command queue.
  typedef struct packed {
    logic                    is_write;
    logic [`DMAD_LEN_W-1:0]  length_field;
    logic                    inline_count_flag;
    logic                    crc_accum_x_enable;
    logic                    crc_accum_y_enable;
    logic                    completion_count_update;
    logic                    silent_transfer;
    logic [`DMAD_BUF_W-1:0]  cbuf_addr;
    logic [31:0]             port_addr;
  } dmad_req_t;

endpackage

// ### design/dmad_buf_file.sv
// Buffer address register file with one load port, one increment port and two read ports.
`timescale 1ns/1ns
`include "dmad_cfg.svh"

module dmad_buf_file (
  input  wire logic                   clk,      // core clock
  input  wire logic                   rst_n,    // synchronous reset, active low
  input  wire logic                   wa_en,    // load strobe from the pipeline
  input  wire logic [`DMAD_IDX_W-1:0] wa_addr,  // load index
  input  wire logic [`DMAD_BUF_W-1:0] wa_data,  // load value
  input  wire logic                   wb_en,    // increment write strobe
  input  wire logic [`DMAD_IDX_W-1:0] wb_addr,  // increment index
  input  wire logic [`DMAD_BUF_W-1:0] wb_data,  // incremented value
  input  wire logic [`DMAD_IDX_W-1:0] ra_addr,  // pipeline read index
  output logic      [`DMAD_BUF_W-1:0] ra_data,  // pipeline read data, next cycle
  input  wire logic [`DMAD_IDX_W-1:0] rb_addr,  // dispatcher read index
  output logic      [`DMAD_BUF_W-1:0] rb_data   // dispatcher read data, next cycle
);

  typedef struct packed {
    logic [`DMAD_BUF_N-1:0][`DMAD_BUF_W-1:0] mem;
    logic [`DMAD_BUF_W-1:0]                  ra;
    logic [`DMAD_BUF_W-1:0]                  rb;
  } dmad_bf_state_t;

  dmad_bf_state_t s_reg;
  dmad_bf_state_t s_next;

  // Reads sample the array before this edge's writes, so a write is seen
  // by a read issued in the following cycle and not earlier.
  always_comb begin
    s_next    = s_reg;
    s_next.ra = s_reg.mem[ra_addr];
    s_next.rb = s_reg.mem[rb_addr];
    if (wa_en) begin
      s_next.mem[wa_addr] = wa_data;
    end
    // The increment is written last so it wins a clash on the same index.
    if (wb_en) begin
      s_next.mem[wb_addr] = wb_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ra_data = s_reg.ra;
  assign rb_data = s_reg.rb;

endmodule // dmad_buf_file

// ### design/dmad_dispatch.sv
// DMA instruction decoder that turns each DMA instruction into a port queue request.
//
// Overview of operation
// (RL1) Bits 31:29 equal 011 mark DMA; bits 28:27 pick port and direction.
// (RL2) Each decoded DMA appends one read or write request to its port queue.
// (RL3) Control field is bits 9:5: inline flag, CRC X, CRC Y, count update, silent.
// (RL4) Auto increment adds 64 to the buffer address register, wrapping modulo 512.
// (RL5) Auto increment exists only while the DMA plus control mode bit is 1.
// (RL6) Plus off: bit 26 is count MSB; plus on: bit 26 requests increment.
// (RL7) Next instruction sees old address, second either, third onward the new.
// (RL8) Inline length is bits 26:19 with plus off, bits 25:19 with plus on.
// (RL9) Without inline count, length and CRC enables come from the alternate count.
// (RL10) Odd counts: port1 read moves all bytes, other operations one byte fewer.
// (RL11) Inline flag set uses inline length and CRC bits; clear uses alternate register.
// (RL12) CRC X enable makes the engine accumulate into the X partial pair.
// (RL13) CRC Y enable makes the engine accumulate into the Y partial pair.
// (RL14) Count update enable bumps transmit busy or receive full counts on completion.
// (RL15) Silent transfer runs the CRC without host data or host intervention.
// (RL16) CRC X, CRC Y and silent bits act on port1 operations only.
// (RL17) Buffer address register gives the cell buffer address; operands give port address.
// (RL18) A full queue holds the instruction until space frees, never dropping it.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "dmad_cfg.svh"

module dmad_dispatch (
  input  wire logic                   clk,           // core clock, 50 MHz
  input  wire logic                   rst_n,         // synchronous reset, active low
  input  wire logic                   instr_valid,   // instruction word presented
  input  wire logic [31:0]            instr,         // instruction word
  input  wire logic [`DMAD_OPND_W-1:0] rsa_val,      // value of the first source register
  input  wire logic [`DMAD_OPND_W-1:0] rsb_val,      // value of the second source register
  input  wire logic                   plus_en,       // DMA plus control mode bit
  input  wire dmad_pkg::dmad_alt_t    alt_count,     // alternate count register value
  input  wire logic                   buf_wr_en,     // pipeline load of a buffer address reg
  input  wire logic [`DMAD_IDX_W-1:0] buf_wr_addr,   // index of the loaded register
  input  wire logic [`DMAD_BUF_W-1:0] buf_wr_data,   // value loaded
  input  wire logic [`DMAD_IDX_W-1:0] buf_rd_addr,   // pipeline read index
  output logic      [`DMAD_BUF_W-1:0] buf_rd_data,   // pipeline read data, next cycle
  output logic                        instr_ready,   // dispatcher can take a DMA
  output logic                        p1_req_valid,  // port1 request present
  output dmad_pkg::dmad_req_t         p1_req,        // port1 request
  input  wire logic                   p1_req_ready,  // port1 queue has space
  output logic                        p2_req_valid,  // port2 request present
  output dmad_pkg::dmad_req_t         p2_req,        // port2 request
  input  wire logic                   p2_req_ready   // port2 queue has space
);

  typedef struct packed {
    dmad_pkg::dmad_state_t  st;
    logic                   ready;
    logic                   p1_valid;
    logic                   p2_valid;
    logic                   to_port2;
    logic                   inc;
    logic [`DMAD_IDX_W-1:0] rla_idx;
    dmad_pkg::dmad_req_t    req;
  } dmad_dp_state_t;

  dmad_dp_state_t s_reg;
  dmad_dp_state_t s_next;

  logic [`DMAD_BUF_W-1:0] rla_val;
  logic                   inc_wr;
  logic [`DMAD_BUF_W-1:0] inc_data;
  logic                   accept;
  logic [1:0]             sel;
  dmad_pkg::dmad_ctrl_t   ctrl;

  // True for any of the four DMA operation codes.
  function automatic logic is_dma(input logic [31:0] w);
    return w[`DMAD_OPC_HI:`DMAD_OPC_LO] == `DMAD_OPC_DMA; // RL1
  endfunction

  // Inline byte count; bit 26 belongs to it only with plus control off.
  function automatic logic [`DMAD_LEN_W-1:0] inline_len(input logic [31:0] w,
                                                        input logic        plus);
    logic [`DMAD_LEN_W-1:0] v;
    v = w[`DMAD_BC_HI:`DMAD_BC_LO]; // RL8
    if (plus) begin
      v = {1'b0, w[`DMAD_BCP_HI:`DMAD_BC_LO]}; // RL6 RL8
    end
    return v;
  endfunction

  // Port1 reads may move bytes; every other path works in pairs and drops the odd byte.
  function automatic logic [`DMAD_LEN_W-1:0] bus_len(input logic [`DMAD_LEN_W-1:0] n,
                                                     input logic [1:0]             op);
    logic [`DMAD_LEN_W-1:0] v;
    v = n;
    if (op != `DMAD_SEL_P1_RD) begin
      v[0] = 1'b0; // RL10
    end
    return v;
  endfunction

  assign sel    = instr[`DMAD_SEL_HI:`DMAD_SEL_LO];
  assign ctrl   = instr[`DMAD_CTL_HI:`DMAD_CTL_LO]; // RL3
  assign accept = (s_reg.st == dmad_pkg::DMAD_IDLE) && s_reg.ready && instr_valid
                  && is_dma(instr);

  // The increment is written in the cycle after the instruction is taken.
  // A read issued in that cycle still returns the old value, one issued a
  // cycle later the new one, which matches the pipeline visibility window.
  assign inc_wr   = (s_reg.st == dmad_pkg::DMAD_FETCH) && s_reg.inc; // RL4 RL7
  assign inc_data = rla_val + `DMAD_RLA_STEP; // RL4

  dmad_buf_file u_buf (
    .clk     (clk),
    .rst_n   (rst_n),
    .wa_en   (buf_wr_en),
    .wa_addr (buf_wr_addr),
    .wa_data (buf_wr_data),
    .wb_en   (inc_wr),
    .wb_addr (s_reg.rla_idx),
    .wb_data (inc_data),
    .ra_addr (buf_rd_addr),
    .ra_data (buf_rd_data),
    .rb_addr (instr[`DMAD_RLA_HI:`DMAD_RLA_LO]),
    .rb_data (rla_val)
  );

  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      dmad_pkg::DMAD_IDLE: begin
        if (accept) begin
          s_next.st       = dmad_pkg::DMAD_FETCH;
          s_next.to_port2 = sel[1]; // RL1
          s_next.inc      = plus_en && instr[`DMAD_INC_BIT]; // RL5 RL6
          s_next.rla_idx  = instr[`DMAD_RLA_HI:`DMAD_RLA_LO];
          s_next.req.is_write = sel[0]; // RL1 RL2
          s_next.req.inline_count_flag = ctrl.inline_count_flag; // RL11
          if (ctrl.inline_count_flag) begin
            s_next.req.length_field = bus_len(inline_len(instr, plus_en), sel); // RL11
            s_next.req.crc_accum_x_enable = ctrl.crc_accum_x_enable; // RL12
            s_next.req.crc_accum_y_enable = ctrl.crc_accum_y_enable; // RL13
          end else begin
            s_next.req.length_field = bus_len(alt_count.length_field, sel); // RL9
            s_next.req.crc_accum_x_enable = alt_count.crc_accum_x_enable; // RL9
            s_next.req.crc_accum_y_enable = alt_count.crc_accum_y_enable; // RL9
          end
          s_next.req.completion_count_update = ctrl.completion_count_update; // RL14
          s_next.req.silent_transfer = ctrl.silent_transfer; // RL15
          if (sel[1]) begin
            s_next.req.crc_accum_x_enable = 1'b0; // RL16
            s_next.req.crc_accum_y_enable = 1'b0; // RL16
            s_next.req.silent_transfer    = 1'b0; // RL16
          end
          s_next.req.port_addr = {rsa_val, rsb_val}; // RL17
        end
      end
      dmad_pkg::DMAD_FETCH: begin
        // The request carries the address before any increment is applied.
        s_next.req.cbuf_addr = rla_val; // RL17
        s_next.st            = dmad_pkg::DMAD_ISSUE;
        s_next.p1_valid      = !s_reg.to_port2; // RL2
        s_next.p2_valid      = s_reg.to_port2; // RL2
      end
      dmad_pkg::DMAD_ISSUE: begin
        // The request stands until its queue takes it.
        if ((s_reg.p1_valid && p1_req_ready) || (s_reg.p2_valid && p2_req_ready)) begin
          s_next.st       = dmad_pkg::DMAD_IDLE; // RL18
          s_next.p1_valid = 1'b0;
          s_next.p2_valid = 1'b0;
        end
      end
      default: begin
        s_next.st       = dmad_pkg::DMAD_IDLE;
        s_next.p1_valid = 1'b0;
        s_next.p2_valid = 1'b0;
      end
    endcase
    s_next.ready = (s_next.st == dmad_pkg::DMAD_IDLE); // RL18
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg.st       <= dmad_pkg::DMAD_IDLE;
      s_reg.ready    <= 1'b1;
      s_reg.p1_valid <= 1'b0;
      s_reg.p2_valid <= 1'b0;
      s_reg.to_port2 <= 1'b0;
      s_reg.inc      <= 1'b0;
      s_reg.rla_idx  <= '0;
      s_reg.req      <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign instr_ready  = s_reg.ready;
  assign p1_req_valid = s_reg.p1_valid;
  assign p2_req_valid = s_reg.p2_valid;
  assign p1_req       = s_reg.req;
  assign p2_req       = s_reg.req;

endmodule // dmad_dispatch

// ### verification/dmad_props.sv
// Port-level checks of the DMA instruction dispatcher.
`timescale 1ns/1ns
`include "dmad_cfg.svh"

module dmad_props (
  input wire logic                    clk,          // core clock
  input wire logic                    rst_n,        // reset, active low
  input wire logic                    instr_valid,  // word presented
  input wire logic [31:0]             instr,        // instruction word
  input wire logic [`DMAD_OPND_W-1:0] rsa_val,      // first operand
  input wire logic [`DMAD_OPND_W-1:0] rsb_val,      // second operand
  input wire logic                    plus_en,      // plus control mode
  input wire dmad_pkg::dmad_alt_t     alt_count,    // alternate count
  input wire logic                    instr_ready,  // dispatcher idle
  input wire logic                    p1_req_valid, // port1 request
  input wire dmad_pkg::dmad_req_t     p1_req,       // request content
  input wire logic                    p1_req_ready, // port1 space
  input wire logic                    p2_req_valid  // port2 request
);
  logic take;
  assign take = instr_ready && instr_valid && instr[31:29] == 3'h3;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence issue_s;
    !instr_ready ##1 (p1_req_valid ^ p2_req_valid);
  endsequence

  take_issue_a: assert property (take |=> issue_s)
    else $error("no request after a DMA word");
  port_sel_a: assert property (take |-> ##2 p2_req_valid == $past(instr[28], 2))
    else $error("wrong port selected");
  dir_sel_a: assert property (take |-> ##2 p1_req.is_write == $past(instr[27], 2))
    else $error("wrong transfer direction");
  port_addr_a: assert property (take |-> ##2
    p1_req.port_addr == {$past(rsa_val, 2), $past(rsb_val, 2)})
    else $error("wrong port address");
  inline_len_a: assert property (take && instr[9] && !plus_en |-> ##2
    p1_req.length_field[7:1] == $past(instr[26:20], 2))
    else $error("wrong inline length");
  plus_len_a: assert property (take && instr[9] && plus_en |-> ##2
    p1_req.length_field[7:1] == {1'b0, $past(instr[25:20], 2)})
    else $error("wrong inline length with plus control");
  alt_len_a: assert property (take && !instr[9] |-> ##2
    p1_req.length_field[7:1] == $past(alt_count.length_field[7:1], 2))
    else $error("alternate length not used");
  odd_round_a: assert property ((p2_req_valid || (p1_req_valid && p1_req.is_write))
    |-> !p1_req.length_field[0])
    else $error("odd length not rounded down");
  port2_clean_a: assert property (p2_req_valid |-> !(p1_req.crc_accum_x_enable
    || p1_req.crc_accum_y_enable || p1_req.silent_transfer))
    else $error("port1-only bits on port2");
  stall_hold_a: assert property (p1_req_valid && !p1_req_ready |=>
    p1_req_valid && $stable(p1_req))
    else $error("request dropped while stalled");
  ignore_word_a: assert property (instr_ready && instr_valid && instr[31:29] != 3'h3
    |=> instr_ready)
    else $error("non-DMA word taken");
endmodule // dmad_props

bind dmad_dispatch dmad_props chk_u (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
  .instr(instr), .rsa_val(rsa_val), .rsb_val(rsb_val), .plus_en(plus_en),
  .alt_count(alt_count), .instr_ready(instr_ready), .p1_req_valid(p1_req_valid),
  .p1_req(p1_req), .p1_req_ready(p1_req_ready), .p2_req_valid(p2_req_valid));

// ### verification/dmad_queue_model.sv
// Port command queues that take requests after a programmable stall.
`timescale 1ns/1ns

module dmad_queue_model (
  input  wire logic                clk,      // core clock
  input  wire logic                rst_n,    // reset, active low
  input  wire logic [3:0]          stall,    // cycles a request waits
  input  wire logic                p1_valid, // port1 request
  input  wire dmad_pkg::dmad_req_t p1_req,   // port1 content
  output logic                     p1_ready, // port1 space
  input  wire logic                p2_valid, // port2 request
  input  wire dmad_pkg::dmad_req_t p2_req,   // port2 content
  output logic                     p2_ready, // port2 space
  output dmad_pkg::dmad_req_t      got_req,  // last accepted request
  output logic                     got_port, // its port, 1 for port2
  output logic [7:0]               got_cnt   // accepted so far
);
  logic [3:0] wait_cnt;
  // A full queue keeps ready low, so the dispatcher must hold its request.
  assign p1_ready = wait_cnt >= stall;
  assign p2_ready = p1_ready;
  always @(posedge clk) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      got_cnt  <= 8'h00;
    end else if ((p1_valid && p1_ready) || (p2_valid && p2_ready)) begin
      wait_cnt <= 4'h0;
      got_cnt  <= got_cnt + 8'h01;
      got_req  <= p1_valid ? p1_req : p2_req;
      got_port <= p2_valid;
    end else if (p1_valid || p2_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // dmad_queue_model

// ### verification/tb.sv
// Self-checking bench of the DMA instruction dispatcher.
`timescale 1ns/1ns

module tb;
  logic clk = 0, rst_n = 0, instr_valid = 0, plus_en = 0, buf_wr_en = 0;
  logic [31:0] instr = 32'h0000_0000;
  logic [15:0] rsa_val = 16'h1234, rsb_val = 16'h5678;
  dmad_pkg::dmad_alt_t alt_count = '0;
  logic [4:0] buf_wr_addr = 5'h00, buf_rd_addr = 5'h00;
  logic [8:0] buf_wr_data = 9'h000, buf_rd_data, d;
  logic instr_ready, p1_req_valid, p2_req_valid, p1_req_ready, p2_req_ready, got_port;
  dmad_pkg::dmad_req_t p1_req, p2_req, got_req, exp;
  logic [3:0] stall = 4'h0;
  logic [7:0] got_cnt, cnt0;
  int fail_count = 0, comparisons = 0, cycles = 0;

  always #10 clk = ~clk;

  dmad_dispatch dut_u (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .rsa_val(rsa_val), .rsb_val(rsb_val), .plus_en(plus_en), .alt_count(alt_count),
    .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data),
    .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data), .instr_ready(instr_ready),
    .p1_req_valid(p1_req_valid), .p1_req(p1_req), .p1_req_ready(p1_req_ready),
    .p2_req_valid(p2_req_valid), .p2_req(p2_req), .p2_req_ready(p2_req_ready));
  dmad_queue_model q_u (.clk(clk), .rst_n(rst_n), .stall(stall), .p1_valid(p1_req_valid),
    .p1_req(p1_req), .p1_ready(p1_req_ready), .p2_valid(p2_req_valid), .p2_req(p2_req),
    .p2_ready(p2_req_ready), .got_req(got_req), .got_port(got_port), .got_cnt(got_cnt));

  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    comparisons++;
    if (got !== want) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic buf_write(input logic [4:0] i, input logic [8:0] v);
    @(posedge clk);
    buf_wr_en <= 1'b1;
    buf_wr_addr <= i;
    buf_wr_data <= v;
    @(posedge clk);
    buf_wr_en <= 1'b0;
  endtask

  task automatic buf_read(input logic [4:0] i);
    @(posedge clk);
    buf_rd_addr <= i;
    @(posedge clk);
    #1 d = buf_rd_data;
  endtask

  // Presents one word and waits, bounded, for the queue to accept a request.
  task automatic issue(input logic [31:0] w, input logic pl, input dmad_pkg::dmad_alt_t a);
    int n;
    n = 0;
    cnt0 = got_cnt;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= w;
    plus_en <= pl;
    alt_count <= a;
    @(posedge clk);
    instr_valid <= 1'b0;
    while (got_cnt == cnt0 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  function automatic logic [31:0] mk(input logic [1:0] op, input logic b26,
                                     input logic [6:0] bc, input logic [4:0] ctl);
    mk = {3'h3, op, b26, bc, 5'h03, 4'h5, ctl, 5'h0A};
  endfunction

  task automatic wrap_up;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      wrap_up;
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    buf_write(5'h03, 9'h1C0);
    for (int op = 0; op < 4; op++) begin
      issue(mk(op[1:0], 1'b1, 7'h2B, 5'h1F), 1'b0, '0);
      exp = '{op[0], (op == 0) ? 8'hAB : 8'hAA, 1'b1, !op[1], !op[1], 1'b1, !op[1],
              9'h1C0, 32'h1234_5678};
      chk(got_req, exp);
      chk(got_port, op[1]);
    end
    buf_read(5'h03);
    chk(d, 9'h1C0);
    $display("inline counts test done");
    stall <= 4'h4;
    issue(mk(2'h1, 1'b1, 7'h7F, 5'h12), 1'b1, '0);
    exp = '{1'b1, 8'h7E, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 9'h1C0, 32'h1234_5678};
    chk(got_req, exp);
    buf_read(5'h03);
    chk(d, 9'h000);
    $display("increment test done");
    stall <= 4'h0;
    for (int k = 0; k < 2; k++) begin
      issue(mk({k[0], k[0]}, 1'b0, 7'h05, 5'h0F), 1'b1, 10'h313);
      exp = '{k[0], k[0] ? 8'h12 : 8'h13, 1'b0, !k[0], !k[0], 1'b1, !k[0],
              9'h000, 32'h1234_5678};
      chk(got_req, exp);
    end
    buf_read(5'h03);
    chk(d, 9'h000);
    $display("alternate count test done");
    cnt0 = got_cnt;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= 32'h4C00_0000;
    @(posedge clk);
    instr_valid <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk(got_cnt, cnt0);
    $display("non-DMA word test done");
    wrap_up;
  end
endmodule // tb
